/* core/lpm_pkg.sv */
package lpm_pkg;
   // ****************************************
   // port addresses
   // ****************************************
   localparam logic [15:0] LPM_INDEX_PORT = 16'h0022;
   localparam logic [15:0] LPM_DATA_PORT = 16'h0023;
   localparam logic [15:0] LPM_ALT_INDEX_PORT = 16'ha4ea;
   localparam logic [15:0] LPM_ALT_DATA_PORT = 16'ha4eb;
   // ****************************************
   // register indices
   // ****************************************
   localparam logic [7:0] LPM_IDX_POWER = 8'h00;
   localparam logic [7:0] LPM_IDX_START = 8'h01;
   localparam logic [7:0] LPM_IDX_STATUS = 8'h01;
   localparam logic [7:0] LPM_IDX_DISP_CNT = 8'h02;
   localparam logic [7:0] LPM_IDX_STBY_CNT = 8'h03;
   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int LPM_START_DISP = 0;
   localparam int LPM_START_STBY = 1;
   localparam int LPM_START_HOLD_BLK = 3;
   localparam int LPM_EXEMPT_LO = 4;
   localparam int LPM_DISP_PWR = 2;
   localparam int LPM_DISK_PWR = 3;
   localparam logic [7:0] LPM_REG_RESET = 8'h00;
   // ****************************************
   // timing
   // ****************************************
   localparam int LPM_CLK_MHZ = 25;
   localparam int LPM_TB_DIV = 65536;
   localparam int LPM_OSC_HALF = 6;
   localparam int LPM_GOOD_US = 10;
   localparam int LPM_GOOD_CYC = LPM_GOOD_US * LPM_CLK_MHZ;
   localparam int LPM_WAKE_US = 100;
   localparam int LPM_WAKE_CYC = LPM_WAKE_US * LPM_CLK_MHZ;
   // ****************************************
   // pin synchroniser slots
   // ****************************************
   localparam int LPM_NPIN = 16;
   localparam int P_BASE = 0;
   localparam int P_TB = 1;
   localparam int P_OSC = 2;
   localparam int P_CPU_CLOCK = 3;
   localparam int P_ADS_B = 4;
   localparam int P_NMI = 5;
   localparam int P_SLOW_REFRESH_STRAP = 6;
   localparam int P_AC = 7;
   localparam int P_BATT_B = 8;
   localparam int P_DISP_ACC = 9;
   localparam int P_KBD_B = 10;
   localparam int P_WAKE = 11;
   localparam int P_HALT = 12;
   localparam int P_HOLDREQ = 13;
   localparam int P_HOLDACK = 14;
   localparam int P_CPURST = 15;
   typedef enum logic [2:0] {
      LPM_RUN = 3'b001,
      LPM_STBY = 3'b010,
      LPM_WAKE = 3'b100
   } lpm_state_t;
endpackage

/* core/lpm_power_manager.sv */
// What this block does
// - index port then data port reach registers
// - base select low moves ports to alternates
// - display timeout count write, expiry cuts display
// - standby timeout count write sets shutoff delay
// - power control bits drive switch outputs directly
// - start bit 0 runs display countdown
// - start bit 1 runs standby countdown
// - start bit 3 blocks hold while halted
// - start bits 4-7 exempt outputs in standby
// - status bits 0-3: nmi, slow refresh, spare
// - status bits 4-7: ac, battery, display, disk
// - display pin high when display countdown expires
// - switch outputs low in standby, except those exempted by start bits 4-7
// - post-standby good pulse after standby
// - cpu reset suppressed in standby
// - wake failure flag when cpu stays asleep
// - slow refresh strap 1 slow, 0 regular
// - keyboard select latched in standby
// - halved system clock, phased by strobe
// - timer clock osc/12 plus buffered osc
// - hold grant when bus cycle granted
// - standby tick paces both countdowns
// - tick is timebase divided by 64k
// - wake interrupt ends sleep
module lpm_power_manager (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] periph_address_bus,
   input wire logic [7:0] periph_data_in,
   output logic [7:0] periph_data_out,
   output logic periph_data_oe,
   input wire logic io_read_strobe_b,
   input wire logic io_write_strobe_b,
   input wire logic port_base_select,
   input wire logic slow_timebase_in,
   input wire logic osc_reference_in,
   input wire logic cpu_clock,
   input wire logic address_strobe_in_b,
   input wire logic aux_nmi_in,
   input wire logic slow_refresh_strap,
   input wire logic ac_power_on_in,
   input wire logic battery_low_in_b,
   input wire logic display_access_sense,
   input wire logic keyboard_ctrl_select_in_b,
   input wire logic wake_interrupt_in,
   input wire logic cpu_halted_in,
   input wire logic hold_request_in,
   input wire logic cpu_hold_ack_in,
   input wire logic cpu_reset_in,
   output logic [7:0] power_switch_outputs,
   output logic display_power_pin,
   output logic post_standby_good_out,
   output logic cpu_reset_out,
   output logic wake_failure_flag,
   output logic keyboard_ctrl_select_out_b,
   output logic halved_system_clock,
   output logic timer_clock_out,
   output logic osc_reference_buffered,
   output logic hold_grant_out,
   output logic hold_request_out,
   output logic standby_tick_clock
);
   import lpm_pkg::*;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [LPM_NPIN-1:0] pin_raw;
   logic [LPM_NPIN-1:0] pin_reg;
   logic [1:0] strobe_raw;
   logic [1:0] strobe_reg;
   logic [1:0] strobe_last_reg;

   assign pin_raw = {cpu_reset_in, cpu_hold_ack_in, hold_request_in,
      cpu_halted_in, wake_interrupt_in, keyboard_ctrl_select_in_b,
      display_access_sense, battery_low_in_b, ac_power_on_in,
      slow_refresh_strap, aux_nmi_in, address_strobe_in_b, cpu_clock,
      osc_reference_in, slow_timebase_in, port_base_select};
   assign strobe_raw = {io_write_strobe_b, io_read_strobe_b};

   genvar gi;
   generate
      for (gi = 0; gi < LPM_NPIN + 2; gi++) begin : g_sync
         localparam logic IDLE_LVL = (gi >= LPM_NPIN) || (gi == P_ADS_B) || (gi == P_KBD_B);
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic f_reg;
         logic raw;
         if (gi < LPM_NPIN) begin : g_pin
            assign raw = pin_raw[gi];
            assign pin_reg[gi] = f_reg;
         end else begin : g_strb
            assign raw = strobe_raw[gi-LPM_NPIN];
            assign strobe_reg[gi-LPM_NPIN] = f_reg;
         end
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               // whole chain starts at the pin's idle level, no false edge
               s1_reg <= IDLE_LVL;
               s2_reg <= IDLE_LVL;
               s3_reg <= IDLE_LVL;
               f_reg <= IDLE_LVL;
            end else begin
               s1_reg <= raw;
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  f_reg <= s3_reg;
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // port decode
   // ****************************************
   logic [7:0] index_reg;
   logic [7:0] index_next;
   wire base_hi = pin_reg[P_BASE];
   wire [15:0] idx_port = base_hi ? LPM_INDEX_PORT : LPM_ALT_INDEX_PORT;
   wire [15:0] dat_port = base_hi ? LPM_DATA_PORT : LPM_ALT_DATA_PORT;
   wire wr_edge = strobe_last_reg[1] && !strobe_reg[1];
   wire hit_idx = periph_address_bus == idx_port;
   wire hit_dat = periph_address_bus == dat_port;
   wire wr_idx = wr_edge && hit_idx;
   wire wr_dat = wr_edge && hit_dat;
   wire wr_power = wr_dat && index_reg == LPM_IDX_POWER;
   wire wr_start = wr_dat && index_reg == LPM_IDX_START;
   wire wr_dcnt = wr_dat && index_reg == LPM_IDX_DISP_CNT;
   wire wr_scnt = wr_dat && index_reg == LPM_IDX_STBY_CNT;
   wire rd_status = !strobe_reg[0] && hit_dat && index_reg == LPM_IDX_STATUS;

   assign index_next = wr_idx ? periph_data_in : index_reg;

   // ****************************************
   // software registers
   // ****************************************
   logic [7:0] power_reg;
   logic [7:0] start_reg;
   logic [7:0] dtime_reg;
   logic [7:0] stime_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strobe_last_reg <= 2'b11;
         index_reg <= LPM_REG_RESET;
         power_reg <= LPM_REG_RESET;
         start_reg <= LPM_REG_RESET;
         dtime_reg <= LPM_REG_RESET;
         stime_reg <= LPM_REG_RESET;
      end else begin
         strobe_last_reg <= strobe_reg;
         index_reg <= index_next;
         if (wr_power) begin
            power_reg <= periph_data_in;
         end
         if (wr_start) begin
            start_reg <= periph_data_in;
         end
         if (wr_dcnt) begin
            dtime_reg <= periph_data_in;
         end
         if (wr_scnt) begin
            stime_reg <= periph_data_in;
         end
      end
   end

   // ****************************************
   // standby tick
   // ****************************************
   logic [15:0] tb_div_reg;
   logic tb_last_reg;
   wire tb_rise = pin_reg[P_TB] && !tb_last_reg;
   wire tick = tb_rise && tb_div_reg == 16'(LPM_TB_DIV - 1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tb_div_reg <= 16'h0000;
         tb_last_reg <= 1'b0;
         standby_tick_clock <= 1'b0;
      end else begin
         tb_last_reg <= pin_reg[P_TB];
         if (tb_rise) begin
            tb_div_reg <= tb_div_reg + 16'h0001;
         end
         standby_tick_clock <= tb_div_reg[15];
      end
   end

   // ****************************************
   // down counters
   // ****************************************
   logic [7:0] dcnt_reg;
   logic [7:0] scnt_reg;
   logic disp_off_reg;
   logic stby_exp;
   wire disp_run = start_reg[LPM_START_DISP];
   wire stby_run = start_reg[LPM_START_STBY];
   wire disp_load = (wr_start && periph_data_in[LPM_START_DISP])
      || pin_reg[P_DISP_ACC];
   wire stby_load = wr_start && periph_data_in[LPM_START_STBY];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dcnt_reg <= LPM_REG_RESET;
         scnt_reg <= LPM_REG_RESET;
         disp_off_reg <= 1'b0;
         stby_exp <= 1'b0;
      end else begin
         if (disp_load) begin
            dcnt_reg <= dtime_reg;
         end else if (disp_run && tick && dcnt_reg != 8'h00) begin
            dcnt_reg <= dcnt_reg - 8'h01;
         end
         disp_off_reg <= disp_run && !disp_load && dcnt_reg == 8'h00;
         if (stby_load) begin
            scnt_reg <= stime_reg;
         end else if (stby_run && tick && scnt_reg != 8'h00) begin
            scnt_reg <= scnt_reg - 8'h01;
         end
         stby_exp <= stby_run && !stby_load && scnt_reg == 8'h00;
      end
   end

   // ****************************************
   // standby state machine
   // ****************************************
   lpm_state_t state_reg;
   lpm_state_t state_next;
   logic [15:0] timer_reg;
   logic [15:0] timer_next;
   logic good_reg;
   logic [15:0] good_cnt_reg;
   wire ads_seen = !pin_reg[P_ADS_B];

   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      case (state_reg)
         LPM_RUN: begin
            if (stby_exp) begin
               state_next = LPM_STBY;
            end
         end
         LPM_STBY: begin
            if (pin_reg[P_WAKE]) begin
               state_next = LPM_WAKE;
               timer_next = 16'h0000;
            end
         end
         LPM_WAKE: begin
            timer_next = timer_reg + 16'h0001;
            if (ads_seen || timer_reg == 16'(LPM_WAKE_CYC - 1)) begin
               state_next = LPM_RUN;
            end
         end
         default: begin
            state_next = LPM_RUN;
         end
      endcase
   end

   wire in_stby = state_reg == LPM_STBY;
   wire leave_stby = in_stby && (state_next != LPM_STBY || stop_stby);
   wire wake_fail = state_reg == LPM_WAKE && !ads_seen
      && timer_reg == 16'(LPM_WAKE_CYC - 1);
   wire stop_stby = wr_start && !periph_data_in[LPM_START_STBY];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= LPM_RUN;
         timer_reg <= 16'h0000;
         good_cnt_reg <= 16'h0000;
         good_reg <= 1'b0;
         wake_failure_flag <= 1'b0;
         post_standby_good_out <= 1'b0;
      end else begin
         state_reg <= stop_stby ? LPM_RUN : state_next;
         timer_reg <= timer_next;
         // own counter, so an early strobe cannot stretch the pulse
         if (leave_stby) begin
            good_cnt_reg <= 16'h0000;
            good_reg <= 1'b1;
         end else if (good_reg) begin
            good_cnt_reg <= good_cnt_reg + 16'h0001;
            if (good_cnt_reg == 16'(LPM_GOOD_CYC - 1)) begin
               good_reg <= 1'b0;
            end
         end
         post_standby_good_out <= good_reg;
         if (wake_fail) begin
            wake_failure_flag <= 1'b1;
         end
      end
   end

   // ****************************************
   // power switch outputs
   // ****************************************
   logic [7:0] pwr_next;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pwr
         wire exempt = gi >= LPM_EXEMPT_LO && start_reg[gi];
         wire disp_cut = gi == LPM_DISP_PWR && disp_off_reg;
         assign pwr_next[gi] = power_reg[gi] && !disp_cut
            && !(in_stby && !exempt);
      end
   endgenerate

   // ****************************************
   // clock generation
   // ****************************************
   logic osc_last_reg;
   logic [2:0] osc_cnt_reg;
   logic cpu_last_reg;
   logic ads_last_reg;
   wire osc_rise = pin_reg[P_OSC] && !osc_last_reg;
   wire cpu_rise = pin_reg[P_CPU_CLOCK] && !cpu_last_reg;
   wire ads_fall = ads_last_reg && !pin_reg[P_ADS_B];
   wire osc_wrap = osc_cnt_reg == 3'(LPM_OSC_HALF - 1);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_last_reg <= 1'b0;
         osc_cnt_reg <= 3'h0;
         cpu_last_reg <= 1'b0;
         ads_last_reg <= 1'b1;
         timer_clock_out <= 1'b0;
         osc_reference_buffered <= 1'b0;
         halved_system_clock <= 1'b0;
      end else begin
         osc_last_reg <= pin_reg[P_OSC];
         cpu_last_reg <= pin_reg[P_CPU_CLOCK];
         ads_last_reg <= pin_reg[P_ADS_B];
         osc_reference_buffered <= pin_reg[P_OSC];
         if (osc_rise) begin
            osc_cnt_reg <= osc_wrap ? 3'h0 : osc_cnt_reg + 3'h1;
            if (osc_wrap) begin
               timer_clock_out <= !timer_clock_out;
            end
         end
         if (ads_fall) begin
            halved_system_clock <= 1'b0;
         end else if (cpu_rise) begin
            halved_system_clock <= !halved_system_clock;
         end
      end
   end

   // ****************************************
   // outputs and readback
   // ****************************************
   wire [7:0] status = {power_switch_outputs[LPM_DISK_PWR],
      power_switch_outputs[LPM_DISP_PWR], pin_reg[P_BATT_B],
      pin_reg[P_AC], 2'b00, pin_reg[P_SLOW_REFRESH_STRAP], pin_reg[P_NMI]};
   wire hold_blk = start_reg[LPM_START_HOLD_BLK] && pin_reg[P_HALT];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         power_switch_outputs <= 8'h00;
         display_power_pin <= 1'b0;
         cpu_reset_out <= 1'b0;
         keyboard_ctrl_select_out_b <= 1'b1;
         hold_grant_out <= 1'b0;
         hold_request_out <= 1'b0;
         periph_data_out <= 8'h00;
         periph_data_oe <= 1'b0;
      end else begin
         power_switch_outputs <= pwr_next;
         display_power_pin <= disp_off_reg;
         cpu_reset_out <= pin_reg[P_CPURST] && !in_stby;
         if (!in_stby) begin
            keyboard_ctrl_select_out_b <= pin_reg[P_KBD_B];
         end
         hold_grant_out <= pin_reg[P_HOLDACK];
         hold_request_out <= pin_reg[P_HOLDREQ] && !hold_blk;
         periph_data_out <= rd_status ? status : 8'h00;
         periph_data_oe <= rd_status;
      end
   end
endmodule // lpm_power_manager

/* verif/lpm_host_model.sv */
// ****
// host cpu model on the peripheral i/o bus
// ****
module lpm_host_model (
   input wire logic clk,
   input wire logic base,
   input wire logic [7:0] rdata,
   input wire logic rdata_oe,
   output logic [15:0] addr,
   output logic [7:0] wdata,
   output logic rd_b,
   output logic wr_b
);
   timeunit 1ns;
   timeprecision 1ps;
   import lpm_pkg::*;
   initial begin
      addr = 16'hffff;
      wdata = 8'hff;
      rd_b = 1'b1;
      wr_b = 1'b1;
   end
   // one write cycle, bus inverted once released
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_b = 1'b0;
      repeat (8) @(negedge clk);
      wr_b = 1'b1;
      addr = ~a;
      wdata = ~d;
      repeat (6) @(negedge clk);
   endtask
   // one read cycle
   task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic o);
      @(negedge clk);
      addr = a;
      rd_b = 1'b0;
      repeat (8) @(negedge clk);
      d = rdata;
      o = rdata_oe;
      rd_b = 1'b1;
      addr = ~a;
      repeat (6) @(negedge clk);
   endtask
   // index first, then data
   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
      io_wr(base ? LPM_INDEX_PORT : LPM_ALT_INDEX_PORT, idx);
      io_wr(base ? LPM_DATA_PORT : LPM_ALT_DATA_PORT, v);
   endtask
   task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d, output logic o);
      io_wr(base ? LPM_INDEX_PORT : LPM_ALT_INDEX_PORT, idx);
      io_rd(base ? LPM_DATA_PORT : LPM_ALT_DATA_PORT, d, o);
   endtask
endmodule // lpm_host_model

/* verif/lpm_power_manager_asserts.sv */
// ****
// port checker
// ****
module lpm_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic io_read_strobe_b,
   input wire logic [7:0] periph_data_out,
   input wire logic periph_data_oe,
   input wire logic osc_reference_in,
   input wire logic osc_reference_buffered,
   input wire logic timer_clock_out,
   input wire logic halved_system_clock,
   input wire logic hold_request_in,
   input wire logic hold_request_out,
   input wire logic cpu_hold_ack_in,
   input wire logic hold_grant_out,
   input wire logic cpu_reset_in,
   input wire logic cpu_reset_out,
   input wire logic post_standby_good_out,
   input wire logic wake_failure_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   oe_source_a: assert property (
      periph_data_oe |-> !$past(io_read_strobe_b, 3) || !$past(io_read_strobe_b, 4)
      || !$past(io_read_strobe_b, 5)) else $error("data driven without read");
   out_zero_a: assert property (
      !periph_data_oe |-> periph_data_out == 8'h00) else $error("data not zero");
   osc_copy_a: assert property (
      $changed(osc_reference_buffered) |-> osc_reference_buffered == $past(osc_reference_in, 3)
      || osc_reference_buffered == $past(osc_reference_in, 4)) else $error("osc copy");
   timer_rate_a: assert property (
      $changed(timer_clock_out) |=> $stable(timer_clock_out) [*8]) else $error("timer rate");
   half_rate_a: assert property (
      $rose(halved_system_clock) |-> ##[3:5] $fell(halved_system_clock))
      else $error("half clock rate");
   hold_pass_a: assert property (
      !hold_request_in [*6] |-> !hold_request_out) else $error("hold without request");
   grant_follow_a: assert property (
      $stable(cpu_hold_ack_in) [*6] |-> hold_grant_out == cpu_hold_ack_in)
      else $error("grant mismatch");
   reset_gate_a: assert property (
      !cpu_reset_in [*6] |-> !cpu_reset_out) else $error("cpu reset without cause");
   good_len_a: assert property (
      $rose(post_standby_good_out) |-> ##249 post_standby_good_out ##1 !post_standby_good_out)
      else $error("good pulse length");
   wake_sticky_a: assert property (
      wake_failure_flag |=> wake_failure_flag) else $error("wake flag dropped");
endmodule // lpm_checker
bind lpm_power_manager lpm_checker chk (
   .clk(clk), .rst_b(rst_b), .io_read_strobe_b(io_read_strobe_b),
   .periph_data_out(periph_data_out), .periph_data_oe(periph_data_oe),
   .osc_reference_in(osc_reference_in), .osc_reference_buffered(osc_reference_buffered),
   .timer_clock_out(timer_clock_out), .halved_system_clock(halved_system_clock),
   .hold_request_in(hold_request_in), .hold_request_out(hold_request_out),
   .cpu_hold_ack_in(cpu_hold_ack_in), .hold_grant_out(hold_grant_out),
   .cpu_reset_in(cpu_reset_in), .cpu_reset_out(cpu_reset_out),
   .post_standby_good_out(post_standby_good_out), .wake_failure_flag(wake_failure_flag)
);

/* verif/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import lpm_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] addr;
   logic [7:0] wdata, dout, pwr_o, dout_s;
   logic rd_b, wr_b, oe, oe_s, dpin, good, crst_o, wfail, kb_o, half, tclk, oscb, grant, hreq_o;
   logic base = 1'b1, tb = 1'b0, osc = 1'b0, cpuc = 1'b0, nmi = 1'b0, strap = 1'b0, ac = 1'b0;
   logic batt_b = 1'b1, kb_b = 1'b1, wake = 1'b0, halt = 1'b0, hreq = 1'b0, hack = 1'b0;
   logic crst = 1'b0, tick;
   logic dacc = 1'b0, ads_b = 1'b1;
   int cnt = 0;
   int bad_count = 0;
   int samples_checked = 0;
   // rows: power value, {battery_b, ac, strap, nmi}, status
   logic [19:0] rows [4] = '{20'ha5040, 20'h5afb3, 20'hff5d1, 20'h00a22};
   always #20 clk = ~clk;
   // pin clocks
   always @(negedge clk) begin
      cnt <= cnt + 1;
      if (cnt % 2 == 0) tb <= ~tb;
      if (cnt % 2 == 1) cpuc <= ~cpuc;
      if (cnt % 6 == 5) osc <= ~osc;
   end
   lpm_power_manager dut (
      .clk(clk), .rst_b(rst_b), .periph_address_bus(addr), .periph_data_in(wdata),
      .periph_data_out(dout), .periph_data_oe(oe), .io_read_strobe_b(rd_b),
      .io_write_strobe_b(wr_b), .port_base_select(base), .slow_timebase_in(tb),
      .osc_reference_in(osc), .cpu_clock(cpuc), .address_strobe_in_b(ads_b),
      .aux_nmi_in(nmi), .slow_refresh_strap(strap), .ac_power_on_in(ac),
      .battery_low_in_b(batt_b), .display_access_sense(dacc),
      .keyboard_ctrl_select_in_b(kb_b), .wake_interrupt_in(wake), .cpu_halted_in(halt),
      .hold_request_in(hreq), .cpu_hold_ack_in(hack), .cpu_reset_in(crst),
      .power_switch_outputs(pwr_o), .display_power_pin(dpin), .post_standby_good_out(good),
      .cpu_reset_out(crst_o), .wake_failure_flag(wfail), .keyboard_ctrl_select_out_b(kb_o),
      .halved_system_clock(half), .timer_clock_out(tclk), .osc_reference_buffered(oscb),
      .hold_grant_out(grant), .hold_request_out(hreq_o), .standby_tick_clock(tick)
   );
   lpm_host_model host (
      .clk(clk), .base(base), .rdata(dout), .rdata_oe(oe), .addr(addr), .wdata(wdata),
      .rd_b(rd_b), .wr_b(wr_b)
   );
   // ****
   // compare and closing
   // ****
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #800000;
      bad_count++;
      report_and_stop();
   end
   // ****
   // main sequence
   // ****
   initial begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      chk8(pwr_o, 8'h00);
      chk1(kb_o, 1'b1);
      chk1(oe, 1'b0);
      foreach (rows[i]) begin
         {batt_b, ac, strap, nmi} = rows[i][11:8];
         host.reg_wr(LPM_IDX_POWER, rows[i][19:12]);
         chk8(pwr_o, rows[i][19:12]);
         host.reg_rd(LPM_IDX_STATUS, dout_s, oe_s);
         chk8(dout_s, rows[i][7:0]);
         chk1(oe_s, 1'b1);
      end
      // refused accesses
      host.reg_wr(LPM_IDX_POWER, 8'h3c);
      host.reg_wr(8'h05, 8'h00);
      host.io_wr(16'h0024, 8'h00);
      chk8(pwr_o, 8'h3c);
      host.reg_rd(LPM_IDX_POWER, dout_s, oe_s);
      chk1(oe_s, 1'b0);
      chk8(dout_s, 8'h00);
      // alternate ports
      base = 1'b0;
      host.reg_wr(LPM_IDX_POWER, 8'h85);
      host.io_wr(LPM_DATA_PORT, 8'h00);
      chk8(pwr_o, 8'h85);
      base = 1'b1;
      // display countdown: no tick holds it, access reloads it, then expiry
      host.reg_wr(LPM_IDX_DISP_CNT, 8'h05);
      host.reg_wr(LPM_IDX_START, 8'h01);
      chk1(dpin, 1'b0);
      host.reg_wr(LPM_IDX_DISP_CNT, 8'h00);
      dacc = 1'b1;
      host.reg_wr(LPM_IDX_START, 8'h01);
      chk1(dpin, 1'b0);
      dacc = 1'b0;
      repeat (8) @(negedge clk);
      chk1(dpin, 1'b1);
      chk8(pwr_o, 8'h81);
      host.reg_wr(LPM_IDX_START, 8'h00);
      chk1(dpin, 1'b0);
      chk8(pwr_o, 8'h85);
      // hold blocking while halted
      {hreq, hack, halt, kb_b} = 4'b1110;
      host.reg_wr(LPM_IDX_START, 8'h08);
      chk1(hreq_o, 1'b0);
      chk1(grant, 1'b1);
      chk1(kb_o, 1'b0);
      {halt, kb_b} = 2'b01;
      repeat (8) @(negedge clk);
      chk1(hreq_o, 1'b1);
      {hreq, hack} = 2'b00;
      // standby with exemptions
      crst = 1'b1;
      host.reg_wr(LPM_IDX_POWER, 8'hff);
      host.reg_wr(LPM_IDX_STBY_CNT, 8'h00);
      chk1(crst_o, 1'b1);
      host.reg_wr(LPM_IDX_START, 8'h32);
      chk8(pwr_o, 8'h30);
      chk1(crst_o, 1'b0);
      kb_b = 1'b0;
      repeat (8) @(negedge clk);
      chk1(kb_o, 1'b1);
      kb_b = 1'b1;
      // wake answered by a cpu strobe in the high phase of the halved clock
      wake = 1'b1;
      repeat (8) @(negedge clk);
      chk1(good, 1'b1);
      wake = 1'b0;
      @(posedge half);
      @(negedge clk);
      ads_b = 1'b0;
      repeat (4) @(negedge clk);
      ads_b = 1'b1;
      repeat (300) @(negedge clk);
      chk1(good, 1'b0);
      chk1(wfail, 1'b0);
      chk8(pwr_o, 8'h30);
      // wake without cpu strobe
      wake = 1'b1;
      repeat (8) @(negedge clk);
      wake = 1'b0;
      repeat (2600) @(negedge clk);
      chk1(wfail, 1'b1);
      chk1(tick, 1'b0);
      // second reset clears the sticky flag
      rst_b = 1'b0;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      chk1(wfail, 1'b0);
      chk8(pwr_o, 8'h00);
      chk1(good, 1'b0);
      report_and_stop();
   end
endmodule // testbench
